/* pic_defines.svh */
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// control bit locations
`define PIC_LOC_000 10'h000
`define PIC_LOC_001 10'h001
`define PIC_LOC_002 10'h002
`define PIC_LOC_003 10'h003
`define PIC_LOC_022 10'h022
`define PIC_LOC_023 10'h023
`define PIC_LOC_EDGE_SEL_ONE 10'h026
`define PIC_LOC_EDGE_SEL_TWO 10'h027

// bit positions inside a location
`define PIC_BIT_GIE 2'h0
`define PIC_BIT_0 2'h0
`define PIC_BIT_1 2'h1
`define PIC_BIT_2 2'h2
`define PIC_BIT_3 2'h3

// reset values
`define PIC_GIE_RST 1'h0
`define PIC_FLAG_RST 11'h000
`define PIC_MASK_RST 11'h7FF
`define PIC_EDGE_SEL_RST 4'h0

// edge codes
`define PIC_EDGE_FALL_ONLY 2'h1

// vectors
`define PIC_VEC_RESET 16'h0000
`define PIC_VEC_EXT0 16'h0002
`define PIC_VEC_EXT1 16'h0004
`define PIC_VEC_TMRA 16'h0006
`define PIC_VEC_TMRB 16'h0008
`define PIC_VEC_TMRC 16'h000A
`define PIC_VEC_TMRD 16'h000C
`define PIC_VEC_SER 16'h000E

`endif

/* pic_pkg.sv */
package pic_pkg;
  typedef enum logic [3:0] {
    PIC_ACK_IDLE = 4'h1,
    PIC_ACK_C1 = 4'h2,
    PIC_ACK_C2 = 4'h4,
    PIC_ACK_C3 = 4'h8
  } pic_ack_state_t;

  typedef enum logic [3:0] {
    PIC_SRC_EXT0 = 4'h0,
    PIC_SRC_EXT1 = 4'h1,
    PIC_SRC_TMRA = 4'h2,
    PIC_SRC_TMRB = 4'h3,
    PIC_SRC_EXT2 = 4'h4,
    PIC_SRC_TMRC = 4'h5,
    PIC_SRC_EXT3 = 4'h6,
    PIC_SRC_TMRD = 4'h7,
    PIC_SRC_EXT4 = 4'h8,
    PIC_SRC_SER1 = 4'h9,
    PIC_SRC_SER2 = 4'hA
  } pic_src_t;

  typedef enum logic [1:0] {
    PIC_EDGE_NONE = 2'h0,
    PIC_EDGE_FALL = 2'h1,
    PIC_EDGE_RISE = 2'h2,
    PIC_EDGE_BOTH = 2'h3
  } pic_edge_t;
endpackage

/* pic_ctrl.sv */
`timescale 1ns/1ps
`include "pic_defines.svh"
// Overview of operation
// - eleven sources: five external pins, four timers, two serial interfaces.
// - every source has flag, mask and vector; one global enable gates all.
// - timer B/ext2, C/ext3, D/ext4 and both serials share vectors.
// - control bits sit at 000-003 and 022-023, bit readable and writable.
// - software can only clear a request flag, never set it.
// - reset clears global enable and flags, sets every mask bit.
// - pending when flag one and mask zero; taken only with enable set.
// - fixed priority encoder yields vector of highest pending source.
// - ack cycle one finishes instruction, two clears enable, pushes, three branches.
// - vectors 0002 to 000E per group, reset and stop cancel use 0000.
// - ext0 highest down to serial lowest; higher pending overrides lower.
// - stop cancel input acts as reset-vector request, only in stop mode.
// - global enable at 000 bit 0, cleared by acknowledge, set by return.
// - ext0 and ext1 flags set on falling edge of active-low pins.
// - ext2 to ext4 flags set on edge chosen by two edge-select registers.
// - edge-select codes none, falling, rising, both; write-only, reset zero.
// - mask blocks the request but leaves the flag untouched.
// - timer flags set by overflow; timer D also by capture edge.
// - serial flags set when transfer completes or is suspended.
module pic_ctrl
  import pic_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [9:0] ram_addr,
  input wire logic [1:0] bit_sel,
  input wire logic bit_wr,
  input wire logic bit_wdata,
  input wire logic bit_rd,
  input wire logic nib_wr,
  input wire logic [3:0] nib_wdata,
  input wire logic ext_irq_pin_0_n,
  input wire logic ext_irq_pin_1_n,
  input wire logic ext_irq_pin_2,
  input wire logic ext_irq_pin_3,
  input wire logic ext_irq_pin_4,
  input wire logic [3:0] timer_ovf,
  input wire logic timer_d_capture,
  input wire logic [1:0] serial_done,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic stop_mode,
  input wire logic stop_cancel_input,
  output logic bit_rd_data,
  output logic irq_req,
  output logic [15:0] vector_addr,
  output logic ack_finish,
  output logic ack_push,
  output logic ack_branch,
  output logic stop_wake,
  output logic global_irq_enable
);

  localparam int NSRC = 11;
  localparam int NPIN = 5;
  localparam int NGRP = 7;

  // location and bit of each flag; its mask is always the next bit up
  localparam logic [9:0] SRC_LOC [NSRC] = '{
    `PIC_LOC_000, `PIC_LOC_001, `PIC_LOC_001, `PIC_LOC_002,
    `PIC_LOC_022, `PIC_LOC_002, `PIC_LOC_022, `PIC_LOC_003,
    `PIC_LOC_023, `PIC_LOC_003, `PIC_LOC_023
  };
  localparam logic [1:0] SRC_BIT [NSRC] = '{
    `PIC_BIT_1, `PIC_BIT_0, `PIC_BIT_2, `PIC_BIT_0,
    `PIC_BIT_0, `PIC_BIT_2, `PIC_BIT_2, `PIC_BIT_0,
    `PIC_BIT_0, `PIC_BIT_2, `PIC_BIT_2
  };
  // vector group of each source, 0 = highest priority
  localparam logic [2:0] SRC_GRP [NSRC] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6
  };
  localparam logic [15:0] GRP_VEC [NGRP] = '{
    `PIC_VEC_EXT0, `PIC_VEC_EXT1, `PIC_VEC_TMRA, `PIC_VEC_TMRB,
    `PIC_VEC_TMRC, `PIC_VEC_TMRD, `PIC_VEC_SER
  };

  logic gie_reg;
  logic [NSRC-1:0] flag_reg;
  logic [NSRC-1:0] mask_reg;
  logic [3:0] edge_sel_one_reg;
  logic [3:0] edge_sel_two_reg;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic [NPIN-1:0] pin_last_reg;
  logic [NPIN-1:0] pin_evt;
  logic [NPIN-1:0] pin_raw;
  logic [1:0] pin_edge [NPIN];
  logic [NSRC-1:0] set_evt;
  logic [NSRC-1:0] sw_clr;
  logic [NSRC-1:0] sw_mask_wr;
  logic [NSRC-1:0] pending;
  logic [NGRP-1:0] grp_pend;
  logic any_pend;
  logic [15:0] vec_next;
  logic rd_next;
  logic gie_wr;
  logic stop_cancel_meta_reg;
  logic stop_cancel_sync_reg;
  pic_ack_state_t ack_state_reg;
  pic_ack_state_t ack_state_next;
  logic take_irq;
  logic irq_req_reg;
  logic [15:0] vec_reg;
  logic finish_reg;
  logic push_reg;
  logic branch_reg;
  logic wake_reg;
  logic rd_data_reg;

  // ---------------- external pins ----------------
  assign pin_raw = {ext_irq_pin_4, ext_irq_pin_3, ext_irq_pin_2,
                    ext_irq_pin_1_n, ext_irq_pin_0_n};

  // ext0/ext1 are fixed falling edge, the rest follow the edge selects
  assign pin_edge[0] = `PIC_EDGE_FALL_ONLY;
  assign pin_edge[1] = `PIC_EDGE_FALL_ONLY;
  assign pin_edge[2] = edge_sel_one_reg[1:0];
  assign pin_edge[3] = edge_sel_one_reg[3:2];
  assign pin_edge[4] = edge_sel_two_reg[1:0];

  genvar p;
  generate
    for (p = 0; p < NPIN; p++) begin : g_pin
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          pin_meta_reg[p] <= 1'h1;
          pin_sync_reg[p] <= 1'h1;
          pin_last_reg[p] <= 1'h1;
        end else begin
          pin_meta_reg[p] <= pin_raw[p];
          pin_sync_reg[p] <= pin_meta_reg[p];
          pin_last_reg[p] <= pin_sync_reg[p];
        end
      end
      // edge detection reads only the second stage and its delayed copy
      always_comb begin
        unique case (pic_edge_t'(pin_edge[p]))
          PIC_EDGE_NONE: pin_evt[p] = 1'h0;
          PIC_EDGE_FALL: pin_evt[p] = pin_last_reg[p] & ~pin_sync_reg[p];
          PIC_EDGE_RISE: pin_evt[p] = ~pin_last_reg[p] & pin_sync_reg[p];
          PIC_EDGE_BOTH: pin_evt[p] = pin_last_reg[p] ^ pin_sync_reg[p];
        endcase
      end
    end
  endgenerate

  // ---------------- hardware set events ----------------
  always_comb begin
    set_evt = '0;
    set_evt[PIC_SRC_EXT0] = pin_evt[0];
    set_evt[PIC_SRC_EXT1] = pin_evt[1];
    set_evt[PIC_SRC_EXT2] = pin_evt[2];
    set_evt[PIC_SRC_EXT3] = pin_evt[3];
    set_evt[PIC_SRC_EXT4] = pin_evt[4];
    set_evt[PIC_SRC_TMRA] = timer_ovf[0];
    set_evt[PIC_SRC_TMRB] = timer_ovf[1];
    set_evt[PIC_SRC_TMRC] = timer_ovf[2];
    // capture edge choice lives in the timer; only its event arrives here
    set_evt[PIC_SRC_TMRD] = timer_ovf[3] | timer_d_capture;
    set_evt[PIC_SRC_SER1] = serial_done[0];
    set_evt[PIC_SRC_SER2] = serial_done[1];
  end

  // ---------------- flags and masks ----------------
  genvar s;
  generate
    for (s = 0; s < NSRC; s++) begin : g_src
      assign sw_clr[s] = bit_wr && ram_addr == SRC_LOC[s]
                         && bit_sel == SRC_BIT[s] && !bit_wdata;
      assign sw_mask_wr[s] = bit_wr && ram_addr == SRC_LOC[s]
                             && bit_sel == 2'(SRC_BIT[s] + 2'h1);
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          flag_reg[s] <= 1'h0;
        end else if (set_evt[s]) begin
          // a set in the clearing cycle wins so no event is lost
          flag_reg[s] <= 1'h1;
        end else if (sw_clr[s]) begin
          flag_reg[s] <= 1'h0;
        end
      end
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          mask_reg[s] <= 1'h1;
        end else if (sw_mask_wr[s]) begin
          mask_reg[s] <= bit_wdata;
        end
      end
      // mask gates the request only, the flag keeps its value
      assign pending[s] = flag_reg[s] & ~mask_reg[s];
    end
  endgenerate

  // ---------------- edge select registers ----------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      edge_sel_one_reg <= `PIC_EDGE_SEL_RST;
    end else if (nib_wr && ram_addr == `PIC_LOC_EDGE_SEL_ONE) begin
      edge_sel_one_reg <= nib_wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      edge_sel_two_reg <= `PIC_EDGE_SEL_RST;
    end else if (nib_wr && ram_addr == `PIC_LOC_EDGE_SEL_TWO) begin
      edge_sel_two_reg <= nib_wdata;
    end
  end

  // ---------------- global enable ----------------
  assign gie_wr = bit_wr && ram_addr == `PIC_LOC_000 && bit_sel == `PIC_BIT_GIE;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gie_reg <= `PIC_GIE_RST;
    end else if (ack_state_reg == PIC_ACK_C2) begin
      gie_reg <= 1'h0;
    end else if (return_from_irq_instr) begin
      gie_reg <= 1'h1;
    end else if (gie_wr) begin
      gie_reg <= bit_wdata;
    end
  end

  // ---------------- priority vector encoder ----------------
  always_comb begin
    grp_pend = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (pending[i]) begin
        grp_pend[SRC_GRP[i]] = 1'h1;
      end
    end
  end

  assign any_pend = |grp_pend;

  // walk from lowest to highest so the highest group overrides
  always_comb begin
    vec_next = `PIC_VEC_RESET;
    for (int g = NGRP - 1; g >= 0; g--) begin
      if (grp_pend[g]) begin
        vec_next = GRP_VEC[g];
      end
    end
  end

  // ---------------- acknowledge sequence ----------------
  assign take_irq = gie_reg && any_pend && instr_boundary;

  always_comb begin
    ack_state_next = ack_state_reg;
    unique case (ack_state_reg)
      PIC_ACK_IDLE: begin
        if (take_irq) begin
          ack_state_next = PIC_ACK_C1;
        end
      end
      PIC_ACK_C1: ack_state_next = PIC_ACK_C2;
      PIC_ACK_C2: ack_state_next = PIC_ACK_C3;
      PIC_ACK_C3: ack_state_next = PIC_ACK_IDLE;
      default: ack_state_next = PIC_ACK_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_state_reg <= PIC_ACK_IDLE;
    end else begin
      ack_state_reg <= ack_state_next;
    end
  end

  // phase outputs decoded from the next state so each leaves a flop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      finish_reg <= 1'h0;
      push_reg <= 1'h0;
      branch_reg <= 1'h0;
    end else begin
      finish_reg <= ack_state_next == PIC_ACK_C1;
      push_reg <= ack_state_next == PIC_ACK_C2
                  || ack_state_next == PIC_ACK_C3;
      branch_reg <= ack_state_next == PIC_ACK_C3;
    end
  end

  // vector frozen at acceptance; later requests wait for the next boundary
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec_reg <= `PIC_VEC_RESET;
    end else if (ack_state_reg == PIC_ACK_IDLE && take_irq) begin
      vec_reg <= vec_next;
    end else if (wake_reg) begin
      vec_reg <= `PIC_VEC_RESET;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_reg <= 1'h0;
    end else begin
      irq_req_reg <= gie_reg && any_pend;
    end
  end

  // ---------------- stop cancel ----------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stop_cancel_meta_reg <= 1'h1;
      stop_cancel_sync_reg <= 1'h1;
    end else begin
      stop_cancel_meta_reg <= stop_cancel_input;
      stop_cancel_sync_reg <= stop_cancel_meta_reg;
    end
  end

  // active low pin; ignored outside stop mode and independent of enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_reg <= 1'h0;
    end else begin
      wake_reg <= stop_mode && !stop_cancel_sync_reg;
    end
  end

  // ---------------- bit reads ----------------
  always_comb begin
    rd_next = 1'h0;
    if (ram_addr == `PIC_LOC_000 && bit_sel == `PIC_BIT_GIE) begin
      rd_next = gie_reg;
    end
    for (int i = 0; i < NSRC; i++) begin
      if (ram_addr == SRC_LOC[i] && bit_sel == SRC_BIT[i]) begin
        rd_next = flag_reg[i];
      end
      if (ram_addr == SRC_LOC[i] && bit_sel == 2'(SRC_BIT[i] + 2'h1)) begin
        rd_next = mask_reg[i];
      end
    end
  end

  // edge selects are write-only and fall through to zero above
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_reg <= 1'h0;
    end else if (bit_rd) begin
      rd_data_reg <= rd_next;
    end
  end

  assign bit_rd_data = rd_data_reg;
  assign irq_req = irq_req_reg;
  assign vector_addr = vec_reg;
  assign ack_finish = finish_reg;
  assign ack_push = push_reg;
  assign ack_branch = branch_reg;
  assign stop_wake = wake_reg;
  assign global_irq_enable = gie_reg;

endmodule // pic_ctrl

/* pic_ctrl_chk.sv */
`timescale 1ns/1ps
module pic_ctrl_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic stop_mode,
  input wire logic bit_rd,
  input wire logic bit_rd_data,
  input wire logic irq_req,
  input wire logic [15:0] vector_addr,
  input wire logic ack_finish,
  input wire logic ack_push,
  input wire logic ack_branch,
  input wire logic stop_wake,
  input wire logic global_irq_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_ack_cycle_order: assert property (ack_finish |=> (!ack_finish && ack_push && !ack_branch)
    ##1 (!ack_finish && ack_push && ack_branch) ##1 !ack_push)
    else $error("ack sequence out of order");
  chk_enable_cleared: assert property (ack_branch |-> !global_irq_enable)
    else $error("enable still set in branch cycle");
  chk_irq_gated: assert property (irq_req |-> global_irq_enable || $past(global_irq_enable))
    else $error("request raised while disabled");
  chk_return_sets: assert property (return_from_irq_instr && !(ack_push && !ack_branch)
    |=> global_irq_enable)
    else $error("return did not set enable");
  chk_vector_legal: assert property (ack_finish |-> vector_addr inside {16'h0002, 16'h0004,
    16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E})
    else $error("vector outside table");
  chk_take_boundary: assert property ($rose(ack_finish) |-> $past(instr_boundary)
    && $past(global_irq_enable))
    else $error("acknowledge without boundary or enable");
  chk_wake_in_stop: assert property (!stop_mode |=> !stop_wake)
    else $error("wake outside stop mode");
  chk_wake_vector: assert property ($rose(stop_wake) |=> vector_addr == 16'h0000)
    else $error("wake vector not zero");
  chk_read_holds: assert property (!bit_rd |=> $stable(bit_rd_data))
    else $error("read data moved without read");
  cov_branch: cover property (ack_branch);
  cov_wake: cover property (stop_wake);
  cov_req: cover property (irq_req && instr_boundary);
endmodule // pic_ctrl_chk

/* pic_core_mdl.sv */
`timescale 1ns/1ps
module pic_core_mdl (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic handler_done,
  input wire logic ack_branch,
  output logic instr_boundary,
  output logic return_from_irq_instr
);
  logic [1:0] cnt_reg;
  logic in_isr_reg;
  // slow core: four-cycle instructions stretch the wait for acceptance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 2'h0;
      instr_boundary <= 1'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      instr_boundary <= slow ? (cnt_reg == 2'h3) : cnt_reg[0];
    end
  end
  // return only from inside a handler, once it has cleared its flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_isr_reg <= 1'h0;
      return_from_irq_instr <= 1'h0;
    end else begin
      return_from_irq_instr <= in_isr_reg && handler_done;
      if (ack_branch) begin
        in_isr_reg <= 1'h1;
      end else if (return_from_irq_instr) begin
        in_isr_reg <= 1'h0;
      end
    end
  end
endmodule // pic_core_mdl

/* pic_ctrl_tb_top.sv */
`timescale 1ns/1ps
module pic_ctrl_tb_top;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic [9:0] ram_addr = 10'h000;
  logic [1:0] bit_sel = 2'h0;
  logic bit_wr = 1'h0;
  logic bit_wdata = 1'h0;
  logic bit_rd = 1'h0;
  logic nib_wr = 1'h0;
  logic [3:0] nib_wdata = 4'h0;
  logic [4:0] pin = 5'h03;
  logic [3:0] timer_ovf = 4'h0;
  logic tcap = 1'h0;
  logic [1:0] serial_done = 2'h0;
  logic stop_mode = 1'h0;
  logic stop_n = 1'h1;
  logic slow = 1'h0;
  logic hdone = 1'h0;
  logic instr_boundary, return_from_irq_instr, bit_rd_data, irq_req;
  logic ack_finish, ack_push, ack_branch, stop_wake, global_irq_enable;
  logic [15:0] vector_addr;
  int num_errors = 0;
  int samples_checked = 0;
  logic [9:0] floc [0:6] = '{10'h000, 10'h001, 10'h001, 10'h002, 10'h002, 10'h003, 10'h003};
  logic [1:0] fbit [0:6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2};
  logic [9:0] locs [0:5] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h022, 10'h023};

  pic_ctrl DUT (.clock(clock), .arst_n(arst_n), .ram_addr(ram_addr), .bit_sel(bit_sel),
    .bit_wr(bit_wr), .bit_wdata(bit_wdata), .bit_rd(bit_rd), .nib_wr(nib_wr), .nib_wdata(nib_wdata),
    .ext_irq_pin_0_n(pin[0]), .ext_irq_pin_1_n(pin[1]), .ext_irq_pin_2(pin[2]),
    .ext_irq_pin_3(pin[3]), .ext_irq_pin_4(pin[4]), .timer_ovf(timer_ovf), .timer_d_capture(tcap),
    .serial_done(serial_done), .instr_boundary(instr_boundary),
    .return_from_irq_instr(return_from_irq_instr), .stop_mode(stop_mode),
    .stop_cancel_input(stop_n), .bit_rd_data(bit_rd_data), .irq_req(irq_req),
    .vector_addr(vector_addr), .ack_finish(ack_finish), .ack_push(ack_push),
    .ack_branch(ack_branch), .stop_wake(stop_wake), .global_irq_enable(global_irq_enable));
  pic_core_mdl u_core (.clock(clock), .arst_n(arst_n), .slow(slow), .handler_done(hdone),
    .ack_branch(ack_branch), .instr_boundary(instr_boundary),
    .return_from_irq_instr(return_from_irq_instr));

  initial begin
    forever #4 clock = ~clock;
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input logic [9:0] a, input logic [1:0] b, input logic d);
    @(posedge clock);
    ram_addr <= a;
    bit_sel <= b;
    bit_wdata <= d;
    bit_wr <= 1'h1;
    @(posedge clock);
    bit_wr <= 1'h0;
  endtask
  task wnib(input logic [9:0] a, input logic [3:0] d);
    @(posedge clock);
    ram_addr <= a;
    nib_wdata <= d;
    nib_wr <= 1'h1;
    @(posedge clock);
    nib_wr <= 1'h0;
  endtask
  task rd(input logic [9:0] a, input logic [1:0] b, input logic e);
    @(posedge clock);
    ram_addr <= a;
    bit_sel <= b;
    bit_rd <= 1'h1;
    @(posedge clock);
    bit_rd <= 1'h0;
    #1 chk("bit", {15'h0000, e}, {15'h0000, bit_rd_data});
  endtask
  task wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (ack_finish !== 1'h1 && n < 80);
    chk("ack_finish", 16'h0001, {15'h0000, ack_finish});
  endtask
  task handler_exit;
    @(posedge clock);
    hdone <= 1'h1;
    @(posedge clock);
    hdone <= 1'h0;
  endtask

  task t_reset;
    logic [3:0] e;
    for (int i = 0; i < 6; i++) begin
      e = (i == 0) ? 4'h4 : 4'hA;
      for (int b = 0; b < 4; b++) begin
        rd(locs[i], b[1:0], e[b]);
      end
    end
    rd(10'h026, 2'h0, 1'h0);
    chk("enable", 16'h0000, {15'h0000, global_irq_enable});
  endtask
  task t_soft;
    wr(10'h002, 2'h0, 1'h1);
    rd(10'h002, 2'h0, 1'h0);
    wr(10'h002, 2'h1, 1'h0);
    rd(10'h002, 2'h1, 1'h0);
    wr(10'h002, 2'h1, 1'h1);
    rd(10'h002, 2'h1, 1'h1);
  endtask
  // capture, second serial, ext3 and ext4 set their flags while masked
  task t_misc;
    @(posedge clock);
    tcap <= 1'h1;
    serial_done <= 2'h2;
    @(posedge clock);
    tcap <= 1'h0;
    serial_done <= 2'h0;
    rd(10'h003, 2'h0, 1'h1);
    rd(10'h023, 2'h2, 1'h1);
    wr(10'h003, 2'h0, 1'h0);
    wr(10'h023, 2'h2, 1'h0);
    wnib(10'h026, 4'h8);
    wnib(10'h027, 4'h2);
    pin[4:3] <= 2'h3;
    tick(6);
    rd(10'h022, 2'h2, 1'h1);
    rd(10'h023, 2'h0, 1'h1);
    wr(10'h022, 2'h2, 1'h0);
    wr(10'h023, 2'h0, 1'h0);
  endtask
  task t_prio;
    @(posedge clock);
    pin[1:0] <= 2'h0;
    timer_ovf <= 4'hF;
    serial_done <= 2'h1;
    @(posedge clock);
    timer_ovf <= 4'h0;
    serial_done <= 2'h0;
    tick(5);
    // enable on, so only the masks can hold the request back
    wr(10'h000, 2'h0, 1'h1);
    tick(2);
    #1 chk("irq_req", 16'h0000, {15'h0000, irq_req});
    wr(10'h000, 2'h0, 1'h0);
    rd(10'h000, 2'h1, 1'h1);
    rd(10'h003, 2'h0, 1'h1);
    rd(10'h003, 2'h2, 1'h1);
    for (int i = 0; i < 7; i++) wr(floc[i], fbit[i] + 2'h1, 1'h0);
    wr(10'h000, 2'h0, 1'h1);
    for (int i = 0; i < 7; i++) begin
      slow <= i[0];
      wait_ack;
      chk("vector", 16'(2 * (i + 1)), vector_addr);
      tick(1);
      #1 chk("ack_push", 16'h0001, {15'h0000, ack_push});
      tick(1);
      #1 chk("ack_branch", 16'h0001, {15'h0000, ack_branch});
      tick(1);
      #1 chk("enable", 16'h0000, {15'h0000, global_irq_enable});
      wr(floc[i], fbit[i], 1'h0);
      handler_exit;
    end
  endtask
  task t_edge;
    for (int c = 0; c < 4; c++) begin
      wnib(10'h026, c[3:0]);
      pin[2] <= 1'h1;
      tick(6);
      rd(10'h022, 2'h0, c[1]);
      wr(10'h022, 2'h0, 1'h0);
      pin[2] <= 1'h0;
      tick(6);
      rd(10'h022, 2'h0, c[0]);
      wr(10'h022, 2'h0, 1'h0);
    end
    pin[2] <= 1'h1;
    wr(10'h022, 2'h1, 1'h0);
    wait_ack;
    chk("vector", 16'h0008, vector_addr);
    tick(3);
    wr(10'h022, 2'h0, 1'h0);
    handler_exit;
  endtask
  task t_stop;
    stop_n <= 1'h0;
    tick(6);
    #1 chk("stop_wake", 16'h0000, {15'h0000, stop_wake});
    @(posedge clock);
    stop_mode <= 1'h1;
    tick(4);
    #1 chk("stop_wake", 16'h0001, {15'h0000, stop_wake});
    @(posedge clock);
    #1 chk("vector", 16'h0000, vector_addr);
    @(posedge clock);
    stop_n <= 1'h1;
    stop_mode <= 1'h0;
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    tick(10);
    arst_n <= 1'h1;
    t_reset();
    t_soft();
    t_misc();
    t_prio();
    t_edge();
    t_stop();
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule // pic_ctrl_tb_top

bind pic_ctrl pic_ctrl_chk u_chk (.clock(clock), .arst_n(arst_n), .instr_boundary(instr_boundary),
  .return_from_irq_instr(return_from_irq_instr), .stop_mode(stop_mode), .bit_rd(bit_rd),
  .bit_rd_data(bit_rd_data), .irq_req(irq_req), .vector_addr(vector_addr), .ack_finish(ack_finish),
  .ack_push(ack_push), .ack_branch(ack_branch), .stop_wake(stop_wake),
  .global_irq_enable(global_irq_enable));
